// [inc/bws_pkg.sv]
// bws_pkg: constants, offsets and carrier types for the window setup and
// translation register bank.
// assumes: one clock domain, config and csr offsets are byte addresses.
package bws_pkg;

    // ------------------------------------------------------------------
    // configuration space offsets (same on primary and secondary side)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_DS_MEM0_XLAT = 12'h094;
    localparam logic [11:0] OFS_DS_MEM2_XLAT = 12'h09c;
    localparam logic [11:0] OFS_DS_MEM3_XLAT = 12'h0a0;
    localparam logic [11:0] OFS_US_MEM1_XLAT = 12'h0a8;
    localparam logic [11:0] OFS_DS_IOM1_SETUP = 12'h0b0;
    localparam logic [11:0] OFS_US_IOM0_SETUP = 12'h0c4;
    localparam logic [11:0] OFS_UNMAPPED = 12'hfff;

    // ------------------------------------------------------------------
    // csr space offsets of the translated bases
    // ------------------------------------------------------------------
    localparam logic [11:0] CSR_DS_MEM0_XLAT = 12'h068;
    localparam logic [11:0] CSR_DS_MEM2_XLAT = 12'h070;
    localparam logic [11:0] CSR_DS_MEM3_XLAT = 12'h074;
    localparam logic [11:0] CSR_US_MEM1_XLAT = 12'h07c;

    // ------------------------------------------------------------------
    // field layout, write masks and reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] XLAT_WMASK = 32'hffff_f000;
    localparam logic [31:0] SETUP_WMASK = 32'hffff_ffcf;
    localparam logic [31:0] XLAT_RST = 32'h0000_0000;
    localparam logic [31:0] SETUP_RST = 32'h0000_0000;
    localparam int SETUP_IO_BIT = 0;
    localparam int SETUP_TYPE_LO = 1;
    localparam int SETUP_TYPE_HI = 2;
    localparam int SETUP_PREF_BIT = 3;
    localparam int SETUP_SIZE_LO = 6;
    localparam int SETUP_SIZE_HI = 30;
    localparam int SETUP_EN_BIT = 31;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_CSR} bws_src_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } bws_req_s;

    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
    } bws_rsp_s;

    typedef struct packed {
        logic valid;
        bws_src_e src;
        logic write;
        logic [11:0] ofs;
        logic [3:0] be;
        logic [31:0] wdata;
    } bws_acc_s;

    typedef struct packed {
        logic valid;
        logic sel;
        logic [31:0] data;
    } bws_rom_s;

    typedef struct packed {
        logic valid;
        logic [1:0] win;
        logic [31:0] addr;
    } bws_fwd_s;

    typedef struct packed {
        logic enable;
        logic io_space;
        logic [1:0] place;
        logic prefetch;
        logic [31:0] bar_mask;
    } bws_win_cfg_s;

    typedef struct packed {
        logic [3:0][31:0] xlat;
        logic [1:0][31:0] setup;
        logic [2:0] rvalid;
        logic [31:0] rdata;
    } bws_top_st_s;

    // byte-lane merge of a write into a register, then the writable mask
    function automatic logic [31:0] bws_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be, input logic [31:0] wmask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res & wmask;
    endfunction

endpackage

// [src/bws_arb.sv]
// bws_arb: picks one of the primary, secondary and csr register accesses.
// assumes: requesters hold their request until their ready is seen high.
`timescale 1ns/1ps
`default_nettype none

module bws_arb
    import bws_pkg::*;
(
    input wire bws_pkg::bws_req_s pri_req,
    input wire bws_pkg::bws_req_s sec_req,
    input wire bws_pkg::bws_req_s csr_req,
    output bws_pkg::bws_acc_s acc,
    output logic pri_rdy,
    output logic sec_rdy,
    output logic csr_rdy
);
    import bws_pkg::*;

    // ------------------------------------------------------------------
    // csr offset folding
    // ------------------------------------------------------------------
    // csr aliases land on the config offset so one decoder serves all
    function automatic logic [11:0] csr_to_cfg(input logic [11:0] a);
        unique case (a)
            CSR_DS_MEM0_XLAT: return OFS_DS_MEM0_XLAT;
            CSR_DS_MEM2_XLAT: return OFS_DS_MEM2_XLAT;
            CSR_DS_MEM3_XLAT: return OFS_DS_MEM3_XLAT;
            CSR_US_MEM1_XLAT: return OFS_US_MEM1_XLAT;
            default: return OFS_UNMAPPED;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // fixed priority: primary, then secondary, then csr
    // ------------------------------------------------------------------
    // fixed priority is enough: config cycles are rare and each takes one clock
    always_comb begin
        acc = '0;
        pri_rdy = pri_req.valid;
        sec_rdy = sec_req.valid && !pri_req.valid;
        csr_rdy = csr_req.valid && !pri_req.valid && !sec_req.valid;
        if (pri_rdy) begin
            acc = '{valid: 1'b1, src: SRC_PRI, write: pri_req.write, ofs: pri_req.addr,
                    be: pri_req.be, wdata: pri_req.wdata};
        end else if (sec_rdy) begin
            acc = '{valid: 1'b1, src: SRC_SEC, write: sec_req.write, ofs: sec_req.addr,
                    be: sec_req.be, wdata: sec_req.wdata};
        end else if (csr_rdy) begin
            acc = '{valid: 1'b1, src: SRC_CSR, write: csr_req.write, ofs: csr_to_cfg(csr_req.addr),
                    be: csr_req.be, wdata: csr_req.wdata};
        end
    end

endmodule
`default_nettype wire

// [src/bws_xlat.sv]
// bws_xlat: swaps the window base of a forwarded address for the translated base.
// assumes: the window hit is decided outside; win_mask is the window's writable bar bits.
`timescale 1ns/1ps
`default_nettype none

module bws_xlat
    import bws_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire bws_pkg::bws_fwd_s fwd_in,
    input wire logic [3:0][31:0] translated_base_field,
    input wire logic [3:0][31:0] win_mask,
    output bws_pkg::bws_fwd_s fwd_out
);
    import bws_pkg::*;

    bws_fwd_s st;
    bws_fwd_s next_st;
    logic [31:0] eff_mask;

    // ------------------------------------------------------------------
    // address substitution
    // ------------------------------------------------------------------
    // only base bits that the bar can hold take part; the rest are ignored
    assign eff_mask = win_mask[fwd_in.win] & XLAT_WMASK;

    always_comb begin
        next_st = '0;
        if (fwd_in.valid) begin
            next_st.valid = 1'b1;
            next_st.win = fwd_in.win;
            // offset inside the window passes through untouched
            next_st.addr = (translated_base_field[fwd_in.win] & eff_mask) | (fwd_in.addr & ~eff_mask);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fwd_out = st;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_xlat_out_timing: assert property (@(posedge clk) disable iff (!rst_n)
        fwd_in.valid |=> fwd_out.valid && fwd_out.win == $past(fwd_in.win))
        else $error("translated address not issued one cycle after request");

    a_xlat_offset_kept: assert property (@(posedge clk) disable iff (!rst_n)
        fwd_in.valid |=> (fwd_out.addr & ~$past(eff_mask)) == ($past(fwd_in.addr) & ~$past(eff_mask)))
        else $error("window offset changed by translation");

    a_xlat_field_used: assert property (@(posedge clk) disable iff (!rst_n)
        fwd_in.valid |=> (fwd_out.addr & $past(eff_mask)) ==
            ($past(translated_base_field[fwd_in.win]) & $past(eff_mask)))
        else $error("translated base bits not taken from base register");

    c_xlat_forward: cover property (@(posedge clk) disable iff (!rst_n) fwd_in.valid ##1 fwd_out.valid);

endmodule
`default_nettype wire

// [src/bws_top.sv]
// bws_top: translated-base and i/o-or-memory setup registers of the bridge windows,
// plus address translation for forwarded memory transactions.
// assumes: config cycles arrive already decoded to the function's offset;
// the serial rom loader and the local processor finish before host enumeration.
`timescale 1ns/1ps
`default_nettype none

module bws_top
    import bws_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire bws_pkg::bws_req_s pri_req,
    input wire bws_pkg::bws_req_s sec_req,
    input wire bws_pkg::bws_req_s csr_req,
    output logic pri_rdy,
    output logic sec_rdy,
    output logic csr_rdy,
    output bws_pkg::bws_rsp_s pri_rsp,
    output bws_pkg::bws_rsp_s sec_rsp,
    output bws_pkg::bws_rsp_s csr_rsp,
    input wire bws_pkg::bws_rom_s rom_ld,
    input wire bws_pkg::bws_fwd_s fwd_in,
    input wire logic [3:0][31:0] win_mask,
    output bws_pkg::bws_fwd_s fwd_out,
    output bws_pkg::bws_win_cfg_s [1:0] win_cfg
);
    import bws_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    bws_top_st_s st;
    bws_top_st_s next_st;
    bws_acc_s acc;
    logic [2:0] xlat_idx;
    logic [1:0] setup_idx;
    logic [3:0][31:0] translated_base_field;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    // {hit, index} of a translated-base register, one decode for all three spaces
    function automatic logic [2:0] xlat_decode(input logic [11:0] ofs);
        unique case (ofs)
            OFS_DS_MEM0_XLAT: return 3'b100;
            OFS_DS_MEM2_XLAT: return 3'b101;
            OFS_DS_MEM3_XLAT: return 3'b110;
            OFS_US_MEM1_XLAT: return 3'b111;
            default: return 3'b000;
        endcase
    endfunction

    // {hit, index} of a setup register; window 1 downstream is index 0
    function automatic logic [1:0] setup_decode(input logic [11:0] ofs);
        unique case (ofs)
            OFS_DS_IOM1_SETUP: return 2'b10;
            OFS_US_IOM0_SETUP: return 2'b11;
            default: return 2'b00;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // access arbitration
    // ------------------------------------------------------------------
    bws_arb u_arb (
        .pri_req(pri_req),
        .sec_req(sec_req),
        .csr_req(csr_req),
        .acc(acc),
        .pri_rdy(pri_rdy),
        .sec_rdy(sec_rdy),
        .csr_rdy(csr_rdy)
    );

    assign xlat_idx = xlat_decode(acc.ofs);
    assign setup_idx = setup_decode(acc.ofs);

    // ------------------------------------------------------------------
    // register file next state
    // ------------------------------------------------------------------
    // setup writes come from the secondary (local processor) side or the rom
    // loader only; the host sees them read-only so it cannot resize a live bar
    always_comb begin
        next_st = st;
        next_st.rvalid = '0;
        if (acc.valid && acc.write && xlat_idx[2]) begin
            // low 12 bits dropped on write, full upper field kept
            next_st.xlat[xlat_idx[1:0]] = bws_merge(st.xlat[xlat_idx[1:0]], acc.wdata, acc.be,
                                                    XLAT_WMASK);
        end
        if (acc.valid && acc.write && setup_idx[1] && acc.src == SRC_SEC) begin
            // reserved bits 5:4 never stored
            next_st.setup[setup_idx[0]] = bws_merge(st.setup[setup_idx[0]], acc.wdata, acc.be,
                                                    SETUP_WMASK);
        end
        if (rom_ld.valid) begin
            // rom load wins a same-cycle clash: it is the power-up image
            next_st.setup[rom_ld.sel] = rom_ld.data & SETUP_WMASK;
        end
        if (acc.valid && !acc.write) begin
            next_st.rvalid[acc.src] = 1'b1;
            if (xlat_idx[2]) begin
                next_st.rdata = st.xlat[xlat_idx[1:0]];
            end else if (setup_idx[1]) begin
                next_st.rdata = st.setup[setup_idx[0]];
            end else begin
                next_st.rdata = '0; // unmapped offset reads zero
            end
        end
    end

    // setup fields clear to zero so every window starts disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st.xlat <= {4{XLAT_RST}};
            st.setup <= {2{SETUP_RST}};
            st.rvalid <= '0;
            st.rdata <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // read answers
    // ------------------------------------------------------------------
    // one shared data register: only one port is granted per cycle
    assign pri_rsp = '{valid: st.rvalid[SRC_PRI], rdata: st.rdata};
    assign sec_rsp = '{valid: st.rvalid[SRC_SEC], rdata: st.rdata};
    assign csr_rsp = '{valid: st.rvalid[SRC_CSR], rdata: st.rdata};

    // ------------------------------------------------------------------
    // window configuration decode for the bar logic
    // ------------------------------------------------------------------
    // type, prefetch and size are passed as stored while bit 31 enables the window; software keeps them legal,
    // nothing here checks type codes, prefetch on i/o or i/o size limits
    always_comb begin
        for (int w = 0; w < 2; w++) begin
            win_cfg[w].enable = st.setup[w][SETUP_EN_BIT];
            win_cfg[w].io_space = st.setup[w][SETUP_EN_BIT] && st.setup[w][SETUP_IO_BIT];
            win_cfg[w].place = st.setup[w][SETUP_EN_BIT] ? st.setup[w][SETUP_TYPE_HI:SETUP_TYPE_LO] : 2'b00;
            win_cfg[w].prefetch = st.setup[w][SETUP_EN_BIT] && st.setup[w][SETUP_PREF_BIT];
            win_cfg[w].bar_mask = '0;
            if (st.setup[w][SETUP_EN_BIT]) begin
                // size bit one: bar bit writable; zero: read-only zero
                win_cfg[w].bar_mask[SETUP_EN_BIT] = 1'b1;
                win_cfg[w].bar_mask[SETUP_SIZE_HI:SETUP_SIZE_LO] = st.setup[w][SETUP_SIZE_HI:SETUP_SIZE_LO];
            end
        end
    end

    // ------------------------------------------------------------------
    // translation of forwarded memory transactions
    // ------------------------------------------------------------------
    assign translated_base_field = st.xlat;

    bws_xlat u_xlat (
        .clk(clk),
        .rst_n(rst_n),
        .fwd_in(fwd_in),
        .translated_base_field(translated_base_field),
        .win_mask(win_mask),
        .fwd_out(fwd_out)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_xlat_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
        st.xlat[0][11:0] == 12'h000 && st.xlat[1][11:0] == 12'h000 &&
        st.xlat[2][11:0] == 12'h000 && st.xlat[3][11:0] == 12'h000)
        else $error("translated base low bits not zero");

    a_xlat_write_store: assert property (@(posedge clk) disable iff (!rst_n)
        acc.valid && acc.write && acc.be == 4'hf && xlat_idx[2] && !(rom_ld.valid && 1'b0)
        |=> st.xlat[$past(xlat_idx[1:0])] == ($past(acc.wdata) & XLAT_WMASK))
        else $error("translated base field not stored");

    a_csr_alias_read: assert property (@(posedge clk) disable iff (!rst_n)
        csr_rdy && !csr_req.write && csr_req.addr == CSR_DS_MEM0_XLAT
        |=> csr_rsp.valid && csr_rsp.rdata == $past(st.xlat[0]))
        else $error("csr alias does not return the translated base");

    a_host_setup_locked: assert property (@(posedge clk) disable iff (!rst_n)
        acc.valid && acc.write && acc.src == SRC_PRI && setup_idx[1] && !rom_ld.valid
        |=> $stable(st.setup))
        else $error("host write changed a setup register");

    a_setup_io_select: assert property (@(posedge clk) disable iff (!rst_n)
        rom_ld.valid |=> win_cfg[$past(rom_ld.sel)].io_space ==
            ($past(rom_ld.data[SETUP_EN_BIT]) && $past(rom_ld.data[SETUP_IO_BIT])))
        else $error("space select does not follow setup bit 0");

    a_setup_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
        acc.valid && !acc.write && setup_idx[1] |=> st.rdata[5:4] == 2'b00)
        else $error("setup reserved bits read nonzero");

    a_bar_mask_size: assert property (@(posedge clk) disable iff (!rst_n)
        rom_ld.valid && rom_ld.data[SETUP_EN_BIT]
        |=> win_cfg[$past(rom_ld.sel)].bar_mask[SETUP_SIZE_HI:SETUP_SIZE_LO] ==
            $past(rom_ld.data[SETUP_SIZE_HI:SETUP_SIZE_LO]))
        else $error("bar writable mask does not follow size field");

    a_disabled_bar_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !win_cfg[0].enable |-> win_cfg[0].bar_mask == 32'h0000_0000 && !win_cfg[0].io_space)
        else $error("disabled window still exposes bar bits");

    a_reset_setup_clear: assert property (@(posedge clk)
        $rose(rst_n) |-> st.setup[0] == SETUP_RST && st.setup[1] == SETUP_RST)
        else $error("setup not cleared by reset");

    c_rom_enable: cover property (@(posedge clk) disable iff (!rst_n)
        rom_ld.valid ##1 win_cfg[rom_ld.sel].enable);
    c_csr_write: cover property (@(posedge clk) disable iff (!rst_n)
        csr_rdy && csr_req.write);
    c_three_way: cover property (@(posedge clk) disable iff (!rst_n)
        pri_req.valid && sec_req.valid && csr_req.valid);

endmodule
`default_nettype wire

// [verification/bws_rom_model.sv]
// bws_rom_model: serial rom preloader that pushes both i/o-or-memory setup words.
// assumes: go is a one-cycle pulse; words[0] feeds sel 0, words[1] feeds sel 1.
`timescale 1ns/1ps
`default_nettype none

module bws_rom_model
    import bws_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [1:0][31:0] words,
    output bws_pkg::bws_rom_s rom_ld
);
    logic beat;

    // ----------------------------------------------------------------
    // two back-to-back beats; idle data is inverted so stale words never look valid
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            beat <= 1'b0;
            rom_ld <= '0;
        end else if (go || beat) begin // load ahead of host enumeration
            rom_ld <= '{1'b1, beat, words[beat]};
            beat <= ~beat;
        end else begin
            rom_ld.valid <= 1'b0;
            rom_ld.data <= ~rom_ld.data;
        end
    end
endmodule
`default_nettype wire

// [verification/bws_top_test.sv]
// bws_top_test: self-checking bench for the window setup and translation bank.
// assumes: bws_top with the bws_pkg carrier types on its ports; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module bws_top_test;
    import bws_pkg::*;
    logic clk, rst_n, go;
    bws_req_s req [3];
    bws_rsp_s rsp [3];
    logic [2:0] rdy;
    bws_rom_s rom_ld;
    bws_fwd_s fwd_in, fwd_out;
    logic [3:0][31:0] win_mask;
    bws_win_cfg_s [1:0] win_cfg;
    logic [1:0][31:0] words;
    logic [31:0] rq [$], base [4], d, a, m;
    logic [33:0] fq [$];
    logic [11:0] cfg_ofs [4] = '{OFS_DS_MEM0_XLAT, OFS_DS_MEM2_XLAT, OFS_DS_MEM3_XLAT, OFS_US_MEM1_XLAT};
    logic [11:0] csr_ofs [4] = '{CSR_DS_MEM0_XLAT, CSR_DS_MEM2_XLAT, CSR_DS_MEM3_XLAT, CSR_US_MEM1_XLAT};
    int num_errors = 0, n_compared = 0, cycles = 0, seed;

    bws_top bws_top_inst (.clk(clk), .rst_n(rst_n), .pri_req(req[0]), .sec_req(req[1]), .csr_req(req[2]),
        .pri_rdy(rdy[0]), .sec_rdy(rdy[1]), .csr_rdy(rdy[2]), .pri_rsp(rsp[0]), .sec_rsp(rsp[1]),
        .csr_rsp(rsp[2]), .rom_ld(rom_ld), .fwd_in(fwd_in), .win_mask(win_mask), .fwd_out(fwd_out),
        .win_cfg(win_cfg));
    bws_rom_model bws_rom_model_inst (.clk(clk), .rst_n(rst_n), .go(go), .words(words), .rom_ld(rom_ld));

    // ----------------------------------------------------------------
    // clock, compare and closing report
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one access: request held until its grant is seen, reads note the expected word
    task automatic acc(input int p, input logic w, input logic [11:0] ad, input logic [31:0] wd,
                       input logic [31:0] e);
        int n;
        n = 0;
        @(negedge clk);
        req[p] = '{1'b1, w, ad, 4'hf, wd};
        do begin
            @(posedge clk);
            n++;
        end while (rdy[p] !== 1'b1 && n < 50);
        if (n >= 50) chk("grant", 1, 0);
        if (!w) rq.push_back(e);
        @(negedge clk);
        req[p] = '0;
    endtask

    // window config view derived from a setup word
    task automatic chk_cfg(input int s, input logic [31:0] v);
        bws_win_cfg_s e;
        e = '{v[31], v[31] & v[0], v[31] ? v[2:1] : 2'b00, v[31] & v[3],
              v[31] ? {1'b1, v[30:6], 6'b0} : 32'h0000_0000};
        chk("win_cfg", e, win_cfg[s]);
    endtask

    // ----------------------------------------------------------------
    // result watcher: oldest note is matched against each answer
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (rsp[0].valid === 1'b1 || rsp[1].valid === 1'b1 || rsp[2].valid === 1'b1) begin
            d = rsp[0].valid ? rsp[0].rdata : (rsp[1].valid ? rsp[1].rdata : rsp[2].rdata);
            if (rq.size() == 0) chk("spare rdata", 0, 1);
            else chk("rdata", rq.pop_front(), d);
        end
        if (fwd_out.valid === 1'b1) begin
            if (fq.size() == 0) chk("spare fwd", 0, 1);
            else chk("fwd win addr", fq.pop_front(), {fwd_out.win, fwd_out.addr});
        end
        if (cycles == 5000) begin
            num_errors++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'h05df273f;
        rst_n = 1'b0;
        go = 1'b0;
        for (int i = 0; i < 3; i++) req[i] = '0;
        fwd_in = '0;
        win_mask = '0;
        words = {32'hffff_f00a, 32'h8000_0031};
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) acc(i % 3, 1'b0, i % 3 == 2 ? csr_ofs[i] : cfg_ofs[i], 0, 0);
        acc(1, 1'b0, OFS_DS_IOM1_SETUP, 0, SETUP_RST);
        acc(0, 1'b0, OFS_US_IOM0_SETUP, 0, SETUP_RST);
        chk_cfg(0, 0);
        $display("reset values done");
        @(negedge clk);
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        repeat (3) @(negedge clk);
        chk_cfg(0, words[0]);
        chk_cfg(1, words[1]);
        acc(0, 1'b0, OFS_DS_IOM1_SETUP, 0, 32'h8000_0001);
        acc(0, 1'b1, OFS_US_IOM0_SETUP, 32'h0000_0000, 0);
        acc(2, 1'b0, OFS_US_IOM0_SETUP, 0, 0);
        acc(1, 1'b0, OFS_US_IOM0_SETUP, 0, 32'hffff_f00a);
        // disabled memory window, type 01b, bits 11:6 clear, reserved bits 5:4 written high
        acc(1, 1'b1, OFS_DS_IOM1_SETUP, 32'h7fff_f032, 0);
        chk_cfg(0, 32'h7fff_f032);
        acc(0, 1'b0, OFS_DS_IOM1_SETUP, 0, 32'h7fff_f002);
        $display("setup registers done");
        for (int i = 0; i < 4; i++) begin
            base[i] = $random(seed);
            acc(i % 3, 1'b1, i % 3 == 2 ? csr_ofs[i] : cfg_ofs[i], base[i], 0);
            base[i] &= XLAT_WMASK;
            acc((i + 1) % 3, 1'b0, (i + 1) % 3 == 2 ? csr_ofs[i] : cfg_ofs[i], 0, base[i]);
            acc((i + 2) % 3, 1'b0, (i + 2) % 3 == 2 ? csr_ofs[i] : cfg_ofs[i], 0, base[i]);
        end
        // primary and csr ask together: primary is served first, csr one cycle later
        fork
            acc(0, 1'b0, OFS_DS_MEM0_XLAT, 0, base[0]);
            acc(2, 1'b0, CSR_US_MEM1_XLAT, 0, base[3]);
        join
        $display("translated bases done");
        for (int i = 0; i < 4; i++) win_mask[i] = 32'hffff_ffff << (i * 5 + 4);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            a = $random(seed);
            m = win_mask[i % 4] & 32'hffff_f000;
            fwd_in = '{1'b1, i[1:0], a};
            fq.push_back({i[1:0], (base[i % 4] & m) | (a & ~m)});
        end
        @(negedge clk);
        fwd_in = '0;
        $display("translation done");
        acc(0, 1'b0, OFS_UNMAPPED, 0, 0);
        acc(2, 1'b0, 12'h080, 0, 0);
        repeat (4) @(negedge clk);
        chk("queues left", 0, rq.size() + fq.size());
        $display("unmapped access done");
        finish_test();
    end
endmodule
`default_nettype wire
